// [kbc_top.sv]
// keypad brightness command interpreter: frame parser, settings, keypad pwm
`timescale 1ns/1ps
// Behaviour
// - button level never below minimum floor in any follow mode
// - floor 00 means no limit; FF keeps buttons at full brightness
// - floor write raises manual button level up to the new floor
// - floor read returns larger of button level and floor
// - floor survives reset from store, default 00
// - follow byte: 00 manual, AA sensor, FF lcd backlight
// - follow mode survives reset from store, default FF
// - follow modes scale keypad brightness by button level
// - follow modes saturate at floor below and button level above
// - lcd follow: lcd_pos_i curve position through gamma drives keypad pwm
// - manual: button level alone drives pwm, floor still applies
// - sensor follow: sensor reading through gamma drives keypad pwm
// - sensor follow with failed sensor forces curve position FF
// - sensor read, no data: raw channel 0 as two bytes, msb first
// - sensor read with data 4C: lux estimate as two bytes
// - outdoor mode: button acts only after 5 s continuous hold
// - after unlock buttons act at once until 5 s without use
// - outdoor byte 00 off, FF on
// - outdoor mode is not stored, off after any reset
module kbc_top
  import kbc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = OUTDOOR_DELAY_CYC
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // serial command link, receive
  input  wire logic                 rx_valid_i,
  input  wire logic [7:0]           rx_data_i,
  output logic                      rx_ready_o,
  // serial command link, reply
  output logic                      tx_valid_o,
  output logic [7:0]                tx_data_o,
  input  wire logic                 tx_ready_i,
  // stored settings, sampled while reset is held
  input  wire logic                 nv_valid_i,
  input  wire logic [7:0]           nv_floor_i,
  input  wire logic [7:0]           nv_mode_i,
  input  wire logic [7:0]           nv_led_i,
  // settings to be stored
  output logic                      nv_save_o,
  output logic [7:0]                button_min_floor_o,
  output logic [7:0]                keypad_follow_mode_o,
  // manual button level from the level command handler
  input  wire logic                 led_wr_i,
  input  wire logic [7:0]           led_data_i,
  output logic [7:0]                button_led_level_o,
  // brightness sources
  input  wire logic [7:0]           lcd_pos_i,
  input  wire logic [15:0]          sensor_raw_i,
  input  wire logic                 sensor_fail_i,
  // keypad
  input  wire logic [BTN_COUNT-1:0] btn_i,
  output logic [BTN_COUNT-1:0]      btn_o,
  output logic                      outdoor_hold_mode_o,
  output logic [7:0]                keypad_duty_o,
  output logic                      keypad_pwm_o
);
  typedef enum logic [2:0] {S_IDLE, S_HDR, S_DATA, S_DCHK, S_EXEC, S_TX} kbc_state_t;

  kbc_state_t state_ff;
  logic [7:0] buf_ff [FRAME_MAX];
  logic [3:0] idx_ff;
  logic [7:0] hsum_ff;
  logic [7:0] dsum_ff;
  logic [7:0] tx_ff [FRAME_MAX];
  logic [3:0] tx_left_ff;
  logic [7:0] floor_ff;
  logic [7:0] mode_ff;
  logic [7:0] led_ff;
  logic       outdoor_ff;
  logic [7:0] duty_ff;
  logic [7:0] pwm_cnt_ff;
  logic       pwm_ff;
  logic       save_ff;

  logic       rx_fire;
  logic [7:0] hsum_nxt;
  logic [7:0] dsum_nxt;
  logic [23:0] cmd;
  logic [7:0] len;
  logic       ack;
  logic       wr_floor;
  logic       wr_mode;
  logic       wr_outdoor;
  logic [7:0] rlen;
  logic [7:0] r0;
  logic [7:0] r1;
  logic [7:0] rep [FRAME_MAX];
  logic [7:0] rep_hchk;
  logic [7:0] rep_dchk;
  logic [15:0] lux;
  logic [23:0] lux_prod;

  assign rx_ready_o = (state_ff != S_EXEC) && (state_ff != S_TX);
  assign rx_fire    = rx_valid_i && rx_ready_o;
  assign hsum_nxt   = hsum_ff + rx_data_i;
  assign dsum_nxt   = dsum_ff + rx_data_i;
  assign cmd        = {buf_ff[2], buf_ff[3], buf_ff[4]};
  assign len        = buf_ff[5];

  // receive side of the frame
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_ff <= S_IDLE;
      idx_ff   <= 4'h0;
      hsum_ff  <= 8'h00;
      dsum_ff  <= 8'h00;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (rx_fire && rx_data_i == LEAD_BYTE) begin
            hsum_ff  <= rx_data_i;
            idx_ff   <= 4'h1;
            state_ff <= S_HDR;
          end
        end
        S_HDR: begin
          if (rx_fire) begin
            hsum_ff <= hsum_nxt;
            idx_ff  <= idx_ff + 4'h1;
            if (idx_ff == HDR_LAST) begin
              dsum_ff <= 8'h00;
              if (hsum_nxt != CHK_TARGET || buf_ff[1] != SECOND_BYTE || len > MAX_LEN) begin
                state_ff <= S_IDLE;
              end else if (len == 8'h00) begin
                state_ff <= S_EXEC;
              end else begin
                state_ff <= S_DATA;
              end
            end
          end
        end
        S_DATA: begin
          if (rx_fire) begin
            dsum_ff <= dsum_nxt;
            idx_ff  <= idx_ff + 4'h1;
            if (idx_ff == DATA_FIRST + 4'(len) - 4'h1) begin
              state_ff <= S_DCHK;
            end
          end
        end
        S_DCHK: begin
          if (rx_fire) begin
            state_ff <= (dsum_nxt == CHK_TARGET) ? S_EXEC : S_IDLE;
          end
        end
        S_EXEC: begin
          state_ff <= ack ? S_TX : S_IDLE;
        end
        S_TX: begin
          if (tx_ready_i && tx_left_ff == 4'h1) begin
            state_ff <= S_IDLE;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < FRAME_MAX; i++) begin
        buf_ff[i] <= 8'h00;
      end
    end else if (rx_fire && state_ff != S_IDLE && state_ff != S_DCHK) begin
      buf_ff[idx_ff] <= rx_data_i;
    end
  end

  // lux estimate from the raw channel 0 count
  assign lux_prod = sensor_raw_i * LUX_GAIN;
  assign lux      = lux_prod[23:8];

  // decode an accepted frame
  always_comb begin
    ack        = 1'b0;
    wr_floor   = 1'b0;
    wr_mode    = 1'b0;
    wr_outdoor = 1'b0;
    rlen       = 8'h01;
    r0         = buf_ff[7];
    r1         = 8'h00;
    case (cmd)
      CMD_FLOOR: begin
        if (len == 8'h01) begin
          ack      = 1'b1;
          wr_floor = 1'b1;
        end else if (len == 8'h00) begin
          ack = 1'b1;
          r0  = (led_ff > floor_ff) ? led_ff : floor_ff;
        end
      end
      CMD_FOLLOW: begin
        if (len == 8'h01) begin
          if (buf_ff[7] == MODE_MANUAL || buf_ff[7] == MODE_SENSOR
              || buf_ff[7] == MODE_LCD) begin
            ack     = 1'b1;
            wr_mode = 1'b1;
          end
        end else if (len == 8'h00) begin
          ack = 1'b1;
          r0  = mode_ff;
        end
      end
      CMD_AMBIENT: begin
        rlen = 8'h02;
        if (len == 8'h00) begin
          ack = 1'b1;
          r0  = sensor_raw_i[15:8];
          r1  = sensor_raw_i[7:0];
        end else if (len == 8'h01 && buf_ff[7] == LUX_SELECT) begin
          ack = 1'b1;
          r0  = lux[15:8];
          r1  = lux[7:0];
        end
      end
      CMD_OUTDOOR: begin
        if (len == 8'h01) begin
          if (buf_ff[7] == OUTDOOR_OFF || buf_ff[7] == OUTDOOR_ON) begin
            ack        = 1'b1;
            wr_outdoor = 1'b1;
          end
        end else if (len == 8'h00) begin
          ack = 1'b1;
          r0  = outdoor_ff ? OUTDOOR_ON : OUTDOOR_OFF;
        end
      end
      default: begin
        ack = 1'b0;
      end
    endcase
  end

  // reply frame with recomputed sums
  assign rep_hchk = CHK_TARGET - 8'(ACK_BYTE + SECOND_BYTE + buf_ff[2] + buf_ff[3]
                                    + buf_ff[4] + rlen);
  assign rep_dchk = CHK_TARGET - 8'(r0 + ((rlen == 8'h02) ? r1 : 8'h00));
  always_comb begin
    rep[0] = ACK_BYTE;
    rep[1] = SECOND_BYTE;
    rep[2] = buf_ff[2];
    rep[3] = buf_ff[3];
    rep[4] = buf_ff[4];
    rep[5] = rlen;
    rep[6] = rep_hchk;
    rep[7] = r0;
    rep[8] = (rlen == 8'h02) ? r1 : rep_dchk;
    rep[9] = rep_dchk;
  end

  // reply goes out as a shift register so the data port is a flop
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_left_ff <= 4'h0;
      for (int i = 0; i < FRAME_MAX; i++) begin
        tx_ff[i] <= 8'h00;
      end
    end else if (state_ff == S_EXEC && ack) begin
      tx_left_ff <= DATA_FIRST + 4'(rlen) + 4'h1;
      for (int i = 0; i < FRAME_MAX; i++) begin
        tx_ff[i] <= rep[i];
      end
    end else if (state_ff == S_TX && tx_ready_i) begin
      tx_left_ff <= tx_left_ff - 4'h1;
      for (int i = 0; i < FRAME_MAX - 1; i++) begin
        tx_ff[i] <= tx_ff[i+1];
      end
      tx_ff[FRAME_MAX-1] <= 8'h00;
    end
  end

  assign tx_valid_o = (state_ff == S_TX);
  assign tx_data_o  = tx_ff[0];

  // stored settings are taken from the store while reset is held
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      floor_ff <= nv_valid_i ? nv_floor_i : FLOOR_DEF;
      mode_ff  <= nv_valid_i ? nv_mode_i : MODE_DEF;
    end else if (state_ff == S_EXEC) begin
      if (wr_floor) begin
        floor_ff <= buf_ff[7];
      end
      if (wr_mode) begin
        mode_ff <= buf_ff[7];
      end
    end
  end

  // manual level: a floor write raises it, a level write cannot go under the floor
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      led_ff <= nv_valid_i ? nv_led_i : LED_DEF;
    end else if (state_ff == S_EXEC && wr_floor) begin
      if (led_ff < buf_ff[7]) begin
        led_ff <= buf_ff[7];
      end
    end else if (led_wr_i) begin
      led_ff <= (led_data_i < floor_ff) ? floor_ff : led_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      outdoor_ff <= 1'b0;
      save_ff    <= 1'b0;
    end else begin
      save_ff <= (state_ff == S_EXEC) && (wr_floor || wr_mode);
      if (state_ff == S_EXEC && wr_outdoor) begin
        outdoor_ff <= (buf_ff[7] == OUTDOOR_ON);
      end
    end
  end

  // keypad brightness path
  kbc_gamma_if gam ();
  logic [7:0] sensor_pos;
  logic [16:0] scaled_prod;
  logic [7:0] scaled;
  logic [7:0] capped;
  logic [7:0] nxt_duty;

  assign sensor_pos = (sensor_raw_i[15:8] != 8'h00) ? 8'hFF : sensor_raw_i[7:0];
  assign gam.pos    = (mode_ff == MODE_SENSOR)
                      ? (sensor_fail_i ? SENSOR_FAIL_POS : sensor_pos)
                      : lcd_pos_i;

  kbc_gamma u_gamma (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .gam       (gam.lookup)
  );

  assign scaled_prod = ({1'b0, gam.level} + 9'h001) * led_ff;
  assign scaled      = scaled_prod[15:8];
  assign capped      = (scaled > led_ff) ? led_ff : scaled;

  always_comb begin
    nxt_duty = (mode_ff == MODE_MANUAL) ? led_ff : capped;
    if (nxt_duty < floor_ff) begin
      nxt_duty = floor_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      duty_ff <= 8'h00;
    end else begin
      duty_ff <= nxt_duty;
    end
  end

  // a duty of FF keeps the output on for the whole period
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pwm_cnt_ff <= 8'h00;
      pwm_ff     <= 1'b0;
    end else begin
      pwm_cnt_ff <= (pwm_cnt_ff == PWM_TOP) ? 8'h00 : pwm_cnt_ff + 8'h01;
      pwm_ff     <= (pwm_cnt_ff < duty_ff);
    end
  end

  kbc_hold #(
    .HOLD_CYC (HOLD_CYC)
  ) u_hold (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .enable_i  (outdoor_ff),
    .btn_i     (btn_i),
    .btn_o     (btn_o)
  );

  assign nv_save_o            = save_ff;
  assign button_min_floor_o   = floor_ff;
  assign keypad_follow_mode_o = mode_ff;
  assign button_led_level_o   = led_ff;
  assign outdoor_hold_mode_o  = outdoor_ff;
  assign keypad_duty_o        = duty_ff;
  assign keypad_pwm_o         = pwm_ff;
endmodule

// [kbc_pkg.sv]
// constants shared by the keypad brightness command block
package kbc_pkg;
  // clock and outdoor hold timing
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned OUTDOOR_DELAY_S   = 5;
  localparam int unsigned OUTDOOR_DELAY_CYC = OUTDOOR_DELAY_S * CLK_HZ;
  localparam int unsigned BTN_COUNT         = 8;
  localparam int unsigned HOLD_CNT_W        = 28;

  // frame layout
  localparam logic [7:0] LEAD_BYTE   = 8'h07;
  localparam logic [7:0] ACK_BYTE    = 8'h06;
  localparam logic [7:0] SECOND_BYTE = 8'hFF;
  localparam logic [7:0] CHK_TARGET  = 8'hFF;
  localparam logic [3:0] HDR_LAST    = 4'h6;
  localparam logic [3:0] DATA_FIRST  = 4'h7;
  localparam logic [7:0] MAX_LEN     = 8'h02;
  localparam int unsigned FRAME_MAX  = 10;

  // command letters
  localparam logic [23:0] CMD_FLOOR   = 24'h474D42;
  localparam logic [23:0] CMD_FOLLOW  = 24'h474246;
  localparam logic [23:0] CMD_AMBIENT = 24'h4C4953;
  localparam logic [23:0] CMD_OUTDOOR = 24'h4F444D;
  localparam logic [7:0]  LUX_SELECT  = 8'h4C;

  // field values
  localparam logic [7:0] MODE_MANUAL = 8'h00;
  localparam logic [7:0] MODE_SENSOR = 8'hAA;
  localparam logic [7:0] MODE_LCD    = 8'hFF;
  localparam logic [7:0] OUTDOOR_OFF = 8'h00;
  localparam logic [7:0] OUTDOOR_ON  = 8'hFF;
  localparam logic [7:0] SENSOR_FAIL_POS = 8'hFF;

  // values after reset when nothing is stored
  localparam logic [7:0] FLOOR_DEF = 8'h00;
  localparam logic [7:0] MODE_DEF  = 8'hFF;
  localparam logic [7:0] LED_DEF   = 8'hFF;

  // lux estimate: raw * gain / 256
  localparam logic [7:0] LUX_GAIN  = 8'h40;
  // pwm counter wraps here so that a duty of 0xFF is fully on
  localparam logic [7:0] PWM_TOP   = 8'hFE;
endpackage

// [kbc_gamma_if.sv]
// curve position in, gamma-corrected keypad level out
`timescale 1ns/1ps
interface kbc_gamma_if;
  logic [7:0] pos;
  logic [7:0] level;
  modport user  (output pos, input level);
  modport lookup (input pos, output level);
endinterface

// [kbc_gamma.sv]
// gamma table mapping a curve position onto the keypad pwm curve
`timescale 1ns/1ps
module kbc_gamma
  import kbc_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  reset_n_i,
  // lookup
  kbc_gamma_if.lookup gam
);
  logic [7:0] rom [256];
  logic [7:0] level_ff;

  // square-law curve, built as constants
  for (genvar g = 0; g < 256; g++) begin : g_rom
    localparam int unsigned SQ = (g * g) / 255;
    assign rom[g] = 8'(SQ);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      level_ff <= 8'h00;
    end else begin
      level_ff <= rom[gam.pos];
    end
  end

  assign gam.level = level_ff;
endmodule

// [kbc_hold.sv]
// outdoor mode button hold gate
`timescale 1ns/1ps
module kbc_hold
  import kbc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = OUTDOOR_DELAY_CYC
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // control
  input  wire logic                 enable_i,
  // buttons
  input  wire logic [BTN_COUNT-1:0] btn_i,
  output logic      [BTN_COUNT-1:0] btn_o
);
  logic [HOLD_CNT_W-1:0] hold_cnt_ff;
  logic [HOLD_CNT_W-1:0] idle_cnt_ff;
  logic                  unlocked_ff;
  logic [BTN_COUNT-1:0]  btn_ff;
  logic                  any_btn;

  assign any_btn = |btn_i;

  // counts continuous press time and idle time
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !enable_i) begin
      hold_cnt_ff <= '0;
      idle_cnt_ff <= '0;
    end else begin
      hold_cnt_ff <= (any_btn && !unlocked_ff) ? hold_cnt_ff + 1'b1 : '0;
      idle_cnt_ff <= any_btn ? '0 : idle_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !enable_i) begin
      unlocked_ff <= 1'b0;
    end else if (!unlocked_ff && any_btn && hold_cnt_ff == HOLD_CNT_W'(HOLD_CYC - 1)) begin
      unlocked_ff <= 1'b1;
    end else if (unlocked_ff && !any_btn && idle_cnt_ff == HOLD_CNT_W'(HOLD_CYC - 1)) begin
      unlocked_ff <= 1'b0;
    end
  end

  // the held button itself goes through once the delay has passed
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      btn_ff <= '0;
    end else if (!enable_i || unlocked_ff) begin
      btn_ff <= btn_i;
    end else begin
      btn_ff <= '0;
    end
  end

  assign btn_o = btn_ff;
endmodule

// [kbc_asserts.sv]
// port checker for the keypad brightness command block
`timescale 1ns/1ps
module kbc_asserts
  import kbc_pkg::*;
(
  // clock and reset
  input logic                 clk_i,
  input logic                 reset_n_i,
  // command link
  input logic                 rx_valid_i,
  input logic                 rx_ready_o,
  input logic                 tx_valid_o,
  input logic [7:0]           tx_data_o,
  input logic                 tx_ready_i,
  // settings
  input logic                 nv_valid_i,
  input logic [7:0]           nv_floor_i,
  input logic [7:0]           nv_mode_i,
  input logic                 nv_save_o,
  input logic [7:0]           button_min_floor_o,
  input logic [7:0]           keypad_follow_mode_o,
  input logic [7:0]           button_led_level_o,
  // keypad
  input logic [BTN_COUNT-1:0] btn_i,
  input logic [BTN_COUNT-1:0] btn_o,
  input logic                 outdoor_hold_mode_o,
  input logic [7:0]           keypad_duty_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence reply_start;
    $rose(tx_valid_o) && tx_ready_i;
  endsequence
  // duty pipeline is at most three stages deep, so four stable samples suffice
  sequence floor_settled;
    $stable(button_min_floor_o) [*4];
  endsequence

  AST_RESET_FLOOR: assert property (!$past(reset_n_i) |-> button_min_floor_o ==
    ($past(nv_valid_i) ? $past(nv_floor_i) : 8'h00)) else $error("floor not loaded");
  AST_RESET_MODE: assert property (!$past(reset_n_i) |-> !outdoor_hold_mode_o &&
    keypad_follow_mode_o == ($past(nv_valid_i) ? $past(nv_mode_i) : 8'hFF))
    else $error("mode or outdoor wrong after reset");
  AST_REPLY_ACK: assert property ($rose(tx_valid_o) |-> tx_data_o == ACK_BYTE &&
    $past(rx_valid_i && rx_ready_o, 2)) else $error("reply start wrong");
  AST_REPLY_ECHO: assert property (reply_start |=> tx_data_o == SECOND_BYTE)
    else $error("second reply byte wrong");
  AST_REPLY_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("reply byte not held");
  AST_SAVE: assert property ($changed(button_min_floor_o) ||
    $changed(keypad_follow_mode_o) |-> nv_save_o) else $error("no save pulse");
  AST_DUTY_FLOOR: assert property (floor_settled |->
    keypad_duty_o >= button_min_floor_o) else $error("duty below floor");
  AST_FLOOR_FULL: assert property (floor_settled ##0 button_min_floor_o == 8'hFF
    |-> keypad_duty_o == 8'hFF) else $error("full floor not full duty");
  AST_LED_FLOOR: assert property ($changed(button_min_floor_o) |-> ##[0:1]
    button_led_level_o >= button_min_floor_o) else $error("level not raised");
  AST_OUTDOOR_OFF: assert property (!outdoor_hold_mode_o [*2] |->
    btn_o == $past(btn_i)) else $error("button not passed");
endmodule

bind kbc_top kbc_asserts i_asserts (.*);

// [kbc_host.sv]
// host model: sends command frames, collects reply bytes
`timescale 1ns/1ps
module kbc_host
  import kbc_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // command bytes
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       rx_ready_i,
  // reply bytes
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] rep[$];
  logic       slow = 1'b0;
  logic       rdy_q;
  logic       vld_q;
  logic [7:0] dat_q;

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b1;
  end

  // sampled mid-cycle so an edge decision never races the block's update
  always @(negedge clk_i) begin
    rdy_q <= rx_ready_i;
    vld_q <= tx_valid_i;
    dat_q <= tx_data_i;
  end

  // slow mode drops reply ready on every other cycle
  always @(posedge clk_i) begin
    if (vld_q && tx_ready_o)
      rep.push_back(dat_q);
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
  end

  task automatic send(input logic [23:0] c, input logic [7:0] len,
                      input logic [15:0] d, input logic bad);
    logic [7:0] f[$];
    int         n;
    f = {LEAD_BYTE, SECOND_BYTE, c[23:16], c[15:8], c[7:0], len};
    f.push_back((CHK_TARGET - f.sum()) ^ {7'h00, bad});
    if (len == 8'h02)
      f.push_back(d[15:8]);
    if (len != 8'h00) begin
      f.push_back(d[7:0]);
      f.push_back(CHK_TARGET - ((len == 8'h02) ? d[15:8] + d[7:0] : d[7:0]));
    end
    rep.delete();
    foreach (f[i]) begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= f[i];
      @(posedge clk_i);
      while (!rdy_q)
        @(posedge clk_i);
    end
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~f[f.size()-1];
    @(posedge clk_i);
    for (n = 0; n < 60 && !rdy_q; n++)
      @(posedge clk_i);
  endtask
endmodule

// [kbc_top_tb_top.sv]
// self-checking testbench for the keypad brightness command block
`timescale 1ns/1ps
module kbc_top_tb_top;
  import kbc_pkg::*;
  localparam int unsigned HOLD = 20;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, rx_valid_i, rx_ready_o, tx_valid_o;
  logic        tx_ready_i, nv_valid_i = 1'b0, nv_save_o, led_wr_i = 1'b0;
  logic        sensor_fail_i = 1'b0, outdoor_hold_mode_o, keypad_pwm_o;
  logic [7:0]  rx_data_i, tx_data_o, nv_floor_i = 8'h00, nv_mode_i = 8'h00;
  logic [7:0]  nv_led_i = 8'h00, led_data_i = 8'h00, lcd_pos_i = 8'h00;
  logic [7:0]  button_min_floor_o, keypad_follow_mode_o, button_led_level_o;
  logic [7:0]  keypad_duty_o, btn_i = 8'h00, btn_o;
  logic [15:0] sensor_raw_i = 16'h0000;
  int          num_errors = 0, n_compared = 0, cycles = 0;

  kbc_top #(.HOLD_CYC(HOLD)) i_dut (.*);
  kbc_host i_host (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_ready_o(tx_ready_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_reply(input logic [23:0] c, input logic [7:0] rl, input logic [15:0] d);
    logic [7:0] f[$];
    f = {ACK_BYTE, SECOND_BYTE, c[23:16], c[15:8], c[7:0], rl};
    f.push_back(CHK_TARGET - f.sum());
    if (rl == 8'h02)
      f.push_back(d[15:8]);
    f.push_back(d[7:0]);
    f.push_back(CHK_TARGET - ((rl == 8'h02) ? d[15:8] + d[7:0] : d[7:0]));
    chk8("rlen", 8'(f.size()), 8'(i_host.rep.size()));
    foreach (f[i])
      chk8("rbyte", f[i], (i < i_host.rep.size()) ? i_host.rep[i] : 8'hXX);
  endtask

  task automatic do_reset(input logic v, input logic [7:0] f, input logic [7:0] m);
    @(posedge clk_i);
    reset_n_i  <= 1'b0;
    nv_valid_i <= v;
    nv_floor_i <= f;
    nv_mode_i  <= m;
    nv_led_i   <= 8'h50;
    repeat (2) @(posedge clk_i);
    reset_n_i  <= 1'b1;
    @(posedge clk_i);
  endtask

  task automatic set_led(input logic [7:0] v);
    led_wr_i   <= 1'b1;
    led_data_i <= v;
    @(posedge clk_i);
    led_wr_i   <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic press(input logic [7:0] b, input int n);
    btn_i <= b;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic t_floor();
    set_led(8'h10);
    i_host.send(CMD_FLOOR, 8'h01, 16'h0030, 1'b0);
    chk_reply(CMD_FLOOR, 8'h01, 16'h0030);
    chk8("led", 8'h30, button_led_level_o);
    set_led(8'h80);
    i_host.send(CMD_FLOOR, 8'h00, 16'h0000, 1'b0);
    chk_reply(CMD_FLOOR, 8'h01, 16'h0080);
    set_led(8'h05);
    chk8("led", 8'h30, button_led_level_o);
    i_host.send(CMD_FLOOR, 8'h00, 16'h0000, 1'b0);
    chk_reply(CMD_FLOOR, 8'h01, 16'h0030);
  endtask

  task automatic t_mode();
    logic [7:0] m[3] = '{MODE_MANUAL, MODE_SENSOR, MODE_LCD};
    foreach (m[i]) begin
      i_host.send(CMD_FOLLOW, 8'h01, {8'h00, m[i]}, 1'b0);
      chk8("mode", m[i], keypad_follow_mode_o);
      i_host.send(CMD_FOLLOW, 8'h00, 16'h0000, 1'b0);
      chk_reply(CMD_FOLLOW, 8'h01, {8'h00, m[i]});
    end
    i_host.send(CMD_FOLLOW, 8'h01, 16'h0055, 1'b0);
    chk8("rlen", 8'h00, 8'(i_host.rep.size()));
    i_host.send(CMD_FOLLOW, 8'h00, 16'h0000, 1'b1);
    chk8("rlen", 8'h00, 8'(i_host.rep.size()));
    chk8("mode", MODE_LCD, keypad_follow_mode_o);
  endtask

  task automatic duty(input logic [7:0] m, input logic [7:0] lcd, input logic [15:0] raw,
                      input logic fail, input logic [7:0] exp);
    i_host.send(CMD_FOLLOW, 8'h01, {8'h00, m}, 1'b0);
    lcd_pos_i     <= lcd;
    sensor_raw_i  <= raw;
    sensor_fail_i <= fail;
    repeat (6) @(posedge clk_i);
    chk8("duty", exp, keypad_duty_o);
  endtask

  task automatic t_duty();
    i_host.send(CMD_FLOOR, 8'h01, 16'h0020, 1'b0);
    set_led(8'h80);
    duty(MODE_MANUAL, 8'hFF, 16'h0000, 1'b0, 8'h80);
    duty(MODE_LCD, 8'h00, 16'h0000, 1'b0, 8'h20);
    duty(MODE_LCD, 8'hC0, 16'h0000, 1'b0, 8'h48);
    duty(MODE_LCD, 8'hFF, 16'h0000, 1'b0, 8'h80);
    duty(MODE_SENSOR, 8'h00, 16'h00C0, 1'b0, 8'h48);
    duty(MODE_SENSOR, 8'h00, 16'h0100, 1'b0, 8'h80);
    duty(MODE_SENSOR, 8'h00, 16'h0000, 1'b1, 8'h80);
    i_host.send(CMD_FLOOR, 8'h01, 16'h00FF, 1'b0);
    duty(MODE_MANUAL, 8'h00, 16'h0000, 1'b0, 8'hFF);
    chk8("pwm", 8'h01, {7'h00, keypad_pwm_o});
    i_host.send(CMD_FLOOR, 8'h01, 16'h0000, 1'b0);
    set_led(8'h00);
    duty(MODE_MANUAL, 8'h00, 16'h0000, 1'b0, 8'h00);
    chk8("pwm", 8'h00, {7'h00, keypad_pwm_o});
  endtask

  task automatic t_ambient();
    sensor_raw_i <= 16'h1234;
    i_host.send(CMD_AMBIENT, 8'h00, 16'h0000, 1'b0);
    chk_reply(CMD_AMBIENT, 8'h02, 16'h1234);
    i_host.slow = 1'b1;
    i_host.send(CMD_AMBIENT, 8'h01, {8'h00, LUX_SELECT}, 1'b0);
    chk_reply(CMD_AMBIENT, 8'h02, 16'h048D);
    i_host.slow = 1'b0;
  endtask

  task automatic t_outdoor();
    i_host.send(CMD_OUTDOOR, 8'h01, {8'h00, OUTDOOR_ON}, 1'b0);
    chk8("out", 8'h01, {7'h00, outdoor_hold_mode_o});
    press(8'h01, HOLD / 2);
    chk8("btn", 8'h00, btn_o);
    press(8'h00, 2);
    press(8'h01, HOLD + 5);
    chk8("btn", 8'h01, btn_o);
    press(8'h02, 2);
    chk8("btn", 8'h02, btn_o);
    press(8'h00, HOLD + 5);
    press(8'h04, 3);
    chk8("btn", 8'h00, btn_o);
    i_host.send(CMD_OUTDOOR, 8'h01, {8'h00, OUTDOOR_OFF}, 1'b0);
    press(8'h08, 2);
    chk8("btn", 8'h08, btn_o);
    press(8'h00, 1);
    i_host.send(CMD_OUTDOOR, 8'h01, {8'h00, OUTDOOR_ON}, 1'b0);
    do_reset(1'b1, 8'h30, MODE_MANUAL);
    chk8("out", 8'h00, {7'h00, outdoor_hold_mode_o});
    chk8("floor", 8'h30, button_min_floor_o);
    chk8("mode", MODE_MANUAL, keypad_follow_mode_o);
  endtask

  initial begin
    do_reset(1'b0, 8'h00, 8'h00);
    chk8("floor", 8'h00, button_min_floor_o);
    chk8("mode", 8'hFF, keypad_follow_mode_o);
    t_floor();
    t_mode();
    t_duty();
    t_ambient();
    t_outdoor();
    print_verdict();
  end
endmodule
